// ---- pkg/mpu_pkg.sv ----
// Package of constants and carriers for the modulo position unit
package mpu_pkg;

	// ************************************************************
	// Widths and counts
	// ************************************************************
	localparam int POS_W    = 32;
	localparam int GAIN_W   = 16;
	localparam int VEL_W    = 32;
	localparam int OPMODE_W = 4;
	localparam int PLS_N    = 4;
	localparam int DOUT_N   = 2;
	localparam int DMODE_W  = 3;

	// Gain fixed point: gains carry this many fraction bits
	localparam int GAIN_SHIFT = 8;

	// ************************************************************
	// Codes
	// ************************************************************
	localparam logic [OPMODE_W-1:0] OPMODE_POSITION = 4'h2;
	localparam logic [DMODE_W-1:0]  DOUT_MODE_GT    = 3'h5;
	localparam logic [DMODE_W-1:0]  DOUT_MODE_LT    = 3'h6;

	// Wrap channels
	localparam int CH_ACT  = 0;
	localparam int CH_CMD  = 1;
	localparam int CH_CAPA = 2;
	localparam int CH_CAPB = 3;
	localparam int CH_TGT  = 4;
	localparam int CH_N    = 5;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic signed [GAIN_W-1:0] KI_DEFAULT  = 16'h0000;
	localparam logic signed [GAIN_W-1:0] KFF_DEFAULT = 16'h0000;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		DIR_POSITIVE,
		DIR_NEGATIVE,
		DIR_SHORTEST,
		DIR_INSIDE
	} mpu_dir_t;

	typedef enum logic {
		PH_INIT,
		PH_RUN
	} mpu_phase_t;

	typedef struct packed {
		logic signed [POS_W-1:0] lo;
		logic signed [POS_W-1:0] hi;
		logic signed [POS_W:0]   len;
		logic                    on;
	} mpu_range_t;

	typedef struct packed {
		logic signed [GAIN_W-1:0] kp;
		logic signed [GAIN_W-1:0] ki;
		logic signed [GAIN_W-1:0] kff;
		logic signed [VEL_W-1:0]  satPos;
		logic signed [VEL_W-1:0]  satNeg;
	} mpu_gain_t;

	typedef struct packed {
		logic signed [POS_W-1:0] lo;
		logic signed [POS_W-1:0] hi;
	} mpu_win_t;

	typedef struct packed {
		logic [DMODE_W-1:0]      mode;
		logic signed [POS_W-1:0] thr;
	} mpu_dout_cfg_t;

endpackage

// ---- hw/mpu_wrap_calc.sv ----
// Modulo wrap of one position into the configured range
module mpu_wrap_calc
	import mpu_pkg::*;
(
	// Position in
	input  wire logic signed [POS_W-1:0] pos,
	input  wire mpu_range_t              rng,
	// Position out
	output logic signed [POS_W-1:0]      wrapped
);

	logic signed [POS_W:0] offs;
	logic signed [POS_W:0] rem;
	logic signed [POS_W:0] fixed;
	logic signed [POS_W:0] sum;

	always_comb begin
		offs  = {pos[POS_W-1], pos} - {rng.lo[POS_W-1], rng.lo};
		// Guard divide by zero; rng.on is low then anyway
		rem   = (rng.len != '0) ? offs % rng.len : '0;
		// Remainder takes the dividend's sign; bring it into [0, len)
		fixed = (rem < 0) ? rem + rng.len : rem;
		sum   = {rng.lo[POS_W-1], rng.lo} + fixed;
		if (rng.on) begin
			wrapped = sum[POS_W-1:0];
		end else begin
			wrapped = pos;
		end
	end

endmodule

// ---- hw/mpu_modulo_unit.sv ----
// Position loop and modulo axis unit of the drive
//
// Contract
// - Default loop: proportional term only
// - Integral saturation ignored when integral gain zero
// - Wrapped position rolls over to range start
// - One enable switches wrap; off means linear
// - Smaller bound is begin, larger is end
// - Absolute move direction follows selected mode
// - Actual and commanded positions reported wrapped
// - Both captured positions reported wrapped
// - Software limits check wrapped actual, stop
// - Out-of-range software limit never limits
// - Limit switch flag true inside window
// - Out-of-range window never raises flag
// - Output modes 5/6: above/below threshold
// - Out-of-range threshold gives constant output
// - Power-up loads actual from multiturn readout
// - Integer-multiple ranges recompute correctly
// - Non-multiple ranges may recompute wrong
// - Loop active only in position mode 2
module mpu_modulo_unit
	import mpu_pkg::*;
(
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          reset,
	input  wire logic                          ce,
	// Mode and loop gains
	input  wire logic [OPMODE_W-1:0]           operatingModeSelect,
	input  wire mpu_gain_t                     positionGains,
	// Feedback and command
	input  wire logic                          fbReadValid,
	input  wire logic signed [POS_W-1:0]       fbReadPosition,
	input  wire logic signed [POS_W-1:0]       fbDelta,
	input  wire logic signed [POS_W-1:0]       commandedPositionRaw,
	// Modulo configuration
	input  wire logic                          wrapEnable,
	input  wire logic signed [POS_W-1:0]       wrapBoundA,
	input  wire logic signed [POS_W-1:0]       wrapBoundB,
	input  wire mpu_dir_t                      absoluteMoveDirection,
	// Capture engines
	input  wire logic                          captureAStrobe,
	input  wire logic                          captureBStrobe,
	// Absolute move request
	input  wire logic                          absMoveStart,
	input  wire logic signed [POS_W-1:0]       absMoveTarget,
	// Limits and position outputs config
	input  wire logic signed [POS_W-1:0]       swLimitPos,
	input  wire logic signed [POS_W-1:0]       swLimitNeg,
	input  wire mpu_win_t [PLS_N-1:0]          plsWindow,
	input  wire mpu_dout_cfg_t [DOUT_N-1:0]    doutConfig,
	// Loop outputs
	output logic                               positionReady,
	output logic signed [VEL_W-1:0]            velocityCommand,
	// Reported positions
	output logic signed [POS_W-1:0]            actualPosition,
	output logic signed [POS_W-1:0]            commandedPosition,
	output logic signed [POS_W-1:0]            captureAPosition,
	output logic signed [POS_W-1:0]            captureBPosition,
	// Absolute move plan
	output logic                               moveValid,
	output logic signed [POS_W:0]              moveDistance,
	output logic                               moveDirPositive,
	// Limit status
	output logic                               swLimitPosHit,
	output logic                               swLimitNegHit,
	output logic                               motionStop,
	output logic [PLS_N-1:0]                   plsFlag,
	output logic [DOUT_N-1:0]                  digitalOut
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		mpu_phase_t              phase;
		logic signed [POS_W-1:0] actRaw;
		logic signed [POS_W-1:0] cmdPrev;
		logic signed [POS_W-1:0] capARaw;
		logic signed [POS_W-1:0] capBRaw;
		logic signed [VEL_W-1:0] integ;
		logic signed [VEL_W-1:0] velCmd;
		logic signed [POS_W-1:0] actOut;
		logic signed [POS_W-1:0] cmdOut;
		logic signed [POS_W-1:0] capAOut;
		logic signed [POS_W-1:0] capBOut;
		logic                    mvValid;
		logic signed [POS_W:0]   mvDist;
		logic                    mvPos;
		logic                    swPos;
		logic                    swNeg;
		logic                    stop;
		logic [PLS_N-1:0]        pls;
		logic [DOUT_N-1:0]       dout;
	} mpu_state_t;

	mpu_state_t st_ff;
	mpu_state_t nxt_st;

	// ************************************************************
	// Range and wrap channels
	// ************************************************************
	mpu_range_t              rng;
	logic signed [POS_W-1:0] chIn  [CH_N];
	logic signed [POS_W-1:0] chOut [CH_N];
	logic signed [POS_W-1:0] actW;
	logic [PLS_N-1:0]        plsHit;
	logic [DOUT_N-1:0]       doutHit;
	logic                    swPosOk;
	logic                    swNegOk;
	logic                    loopOn;

	// Either setting may hold the begin
	assign rng.lo  = (wrapBoundA < wrapBoundB) ? wrapBoundA : wrapBoundB;
	assign rng.hi  = (wrapBoundA < wrapBoundB) ? wrapBoundB : wrapBoundA;
	assign rng.len = {rng.hi[POS_W-1], rng.hi} - {rng.lo[POS_W-1], rng.lo};
	// Empty range would divide by zero, so it counts as off
	assign rng.on  = wrapEnable && (rng.len != '0);

	assign chIn[CH_ACT]  = st_ff.actRaw;
	assign chIn[CH_CMD]  = commandedPositionRaw;
	assign chIn[CH_CAPA] = st_ff.capARaw;
	assign chIn[CH_CAPB] = st_ff.capBRaw;
	assign chIn[CH_TGT]  = absMoveTarget;
	assign actW          = chOut[CH_ACT];
	assign loopOn = (operatingModeSelect == OPMODE_POSITION) &&
		(st_ff.phase == PH_RUN);

	function automatic logic inRange(input logic signed [POS_W-1:0] x,
		input mpu_range_t r);
		inRange = !r.on || ((x >= r.lo) && (x < r.hi));
	endfunction

	// Position is wrapped from the raw count each time, so after a power
	// cycle the result is right only if the feedback span is a whole
	// multiple of the range; otherwise it may be off.
	genvar g;
	generate
		for (g = 0; g < CH_N; g++) begin : gWrap
			mpu_wrap_calc uWrap (
				.pos     (chIn[g]),
				.rng     (rng),
				.wrapped (chOut[g])
			);
		end
		for (g = 0; g < PLS_N; g++) begin : gPls
			assign plsHit[g] = inRange(plsWindow[g].lo, rng) &&
				inRange(plsWindow[g].hi, rng) &&
				(actW >= plsWindow[g].lo) &&
				(actW <= plsWindow[g].hi);
		end
		for (g = 0; g < DOUT_N; g++) begin : gDout
			// Out-of-range threshold makes the compare constant
			assign doutHit[g] =
				(doutConfig[g].mode == DOUT_MODE_GT) ?
					(actW > doutConfig[g].thr) :
				(doutConfig[g].mode == DOUT_MODE_LT) ?
					(actW < doutConfig[g].thr) : 1'b0;
		end
	endgenerate

	assign swPosOk = inRange(swLimitPos, rng);
	assign swNegOk = inRange(swLimitNeg, rng);

	// ************************************************************
	// Next state
	// ************************************************************
	logic signed [POS_W-1:0]        err;
	logic signed [POS_W-1:0]        cmdStep;
	logic signed [POS_W+GAIN_W-1:0] pProd;
	logic signed [POS_W+GAIN_W-1:0] iProd;
	logic signed [POS_W+GAIN_W-1:0] fProd;
	logic signed [VEL_W:0]          iSum;
	logic signed [VEL_W-1:0]        vel;
	logic signed [POS_W:0]          dRaw;
	logic signed [POS_W:0]          half;
	logic signed [POS_W:0]          dSel;
	logic                           stopNow;

	always_comb begin
		nxt_st  = st_ff;
		err     = commandedPositionRaw - st_ff.actRaw;
		cmdStep = commandedPositionRaw - st_ff.cmdPrev;
		pProd   = (positionGains.kp * err) >>> GAIN_SHIFT;
		iProd   = (positionGains.ki * err) >>> GAIN_SHIFT;
		fProd   = (positionGains.kff * cmdStep) >>> GAIN_SHIFT;
		iSum    = {st_ff.integ[VEL_W-1], st_ff.integ} +
			{iProd[VEL_W-1], iProd[VEL_W-1:0]};
		stopNow = (swPosOk && (actW > swLimitPos)) ||
			(swNegOk && (actW < swLimitNeg));
		// Zero gains leave a pure proportional loop
		vel = pProd[VEL_W-1:0] + fProd[VEL_W-1:0];
		if (positionGains.ki != KI_DEFAULT) begin
			vel = vel + st_ff.integ;
		end
		half = rng.len >>> 1;
		if (rng.on) begin
			dRaw = {chOut[CH_TGT][POS_W-1], chOut[CH_TGT]} -
				{actW[POS_W-1], actW};
		end else begin
			dRaw = {absMoveTarget[POS_W-1], absMoveTarget} -
				{st_ff.actRaw[POS_W-1], st_ff.actRaw};
		end
		dSel = dRaw;
		if (rng.on) begin
			unique case (absoluteMoveDirection)
				DIR_POSITIVE: begin
					if (dRaw < 0) dSel = dRaw + rng.len;
				end
				DIR_NEGATIVE: begin
					if (dRaw > 0) dSel = dRaw - rng.len;
				end
				DIR_SHORTEST: begin
					if (dRaw > half) dSel = dRaw - rng.len;
					else if (dRaw < -half) dSel = dRaw + rng.len;
				end
				DIR_INSIDE: begin
					dSel = dRaw;
				end
			endcase
		end
		if (ce) begin
			nxt_st.mvValid = 1'b0;
			unique case (st_ff.phase)
				PH_INIT: begin
					if (fbReadValid) begin
						nxt_st.actRaw = fbReadPosition;
						nxt_st.phase  = PH_RUN;
					end
				end
				PH_RUN: begin
					nxt_st.actRaw = st_ff.actRaw + fbDelta;
				end
			endcase
			nxt_st.cmdPrev = commandedPositionRaw;
			if (captureAStrobe) nxt_st.capARaw = st_ff.actRaw;
			if (captureBStrobe) nxt_st.capBRaw = st_ff.actRaw;
			// Stored saturation values only matter with a live integral
			if (!loopOn || positionGains.ki == KI_DEFAULT) begin
				nxt_st.integ = '0;
			end else if (iSum > positionGains.satPos) begin
				nxt_st.integ = positionGains.satPos;
			end else if (iSum < positionGains.satNeg) begin
				nxt_st.integ = positionGains.satNeg;
			end else begin
				nxt_st.integ = iSum[VEL_W-1:0];
			end
			nxt_st.velCmd  = (loopOn && !stopNow) ? vel : '0;
			nxt_st.actOut  = actW;
			nxt_st.cmdOut  = chOut[CH_CMD];
			nxt_st.capAOut = chOut[CH_CAPA];
			nxt_st.capBOut = chOut[CH_CAPB];
			if (absMoveStart && loopOn) begin
				nxt_st.mvValid = 1'b1;
				nxt_st.mvDist  = dSel;
				nxt_st.mvPos   = dSel > 0;
			end
			nxt_st.swPos = swPosOk && (actW > swLimitPos);
			nxt_st.swNeg = swNegOk && (actW < swLimitNeg);
			nxt_st.stop  = stopNow;
			nxt_st.pls   = plsHit;
			nxt_st.dout  = doutHit;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign positionReady     = (st_ff.phase == PH_RUN);
	assign velocityCommand   = st_ff.velCmd;
	assign actualPosition    = st_ff.actOut;
	assign commandedPosition = st_ff.cmdOut;
	assign captureAPosition  = st_ff.capAOut;
	assign captureBPosition  = st_ff.capBOut;
	assign moveValid         = st_ff.mvValid;
	assign moveDistance      = st_ff.mvDist;
	assign moveDirPositive   = st_ff.mvPos;
	assign swLimitPosHit     = st_ff.swPos;
	assign swLimitNegHit     = st_ff.swNeg;
	assign motionStop        = st_ff.stop;
	assign plsFlag           = st_ff.pls;
	assign digitalOut        = st_ff.dout;

	// ************************************************************
	// Checks
	// ************************************************************
	loop_mode_gate_a: assert property (@(posedge clk) disable iff (reset)
		ce && (operatingModeSelect != OPMODE_POSITION) |=> velocityCommand == 0)
		else $error("velocity command outside position mode");
	int_zero_gain_a: assert property (@(posedge clk) disable iff (reset)
		ce && (positionGains.ki == KI_DEFAULT) |=> st_ff.integ == 0)
		else $error("integrator active with zero gain");
	wrap_in_range_a: assert property (@(posedge clk) disable iff (reset)
		rng.on |-> (actW >= rng.lo) && (actW < rng.hi))
		else $error("wrapped actual outside range");
	linear_report_a: assert property (@(posedge clk) disable iff (reset)
		ce && !wrapEnable |=> actualPosition == $past(st_ff.actRaw))
		else $error("linear report differs from raw");
	bound_order_a: assert property (@(posedge clk) disable iff (reset)
		rng.lo <= rng.hi && (rng.lo == wrapBoundA || rng.lo == wrapBoundB))
		else $error("range bounds misordered");
	init_load_a: assert property (@(posedge clk) disable iff (reset)
		ce && st_ff.phase == PH_INIT && fbReadValid
		|=> st_ff.actRaw == $past(fbReadPosition) && positionReady)
		else $error("power-up position not loaded");
	sw_limit_off_a: assert property (@(posedge clk) disable iff (reset)
		ce && rng.on && !inRange(swLimitPos, rng) |=> !swLimitPosHit)
		else $error("out-of-range limit fired");
	pls_window_off_a: assert property (@(posedge clk) disable iff (reset)
		ce && !inRange(plsWindow[0].hi, rng) |=> !plsFlag[0])
		else $error("out-of-range window flagged");
	dout_gt_a: assert property (@(posedge clk) disable iff (reset)
		ce && doutConfig[0].mode == DOUT_MODE_GT && actW > doutConfig[0].thr
		|=> digitalOut[0])
		else $error("greater-than output not active");
	shortest_move_a: assert property (@(posedge clk) disable iff (reset)
		moveValid && rng.on && $past(absoluteMoveDirection) == DIR_SHORTEST
		|-> (moveDistance <= half) && (moveDistance >= -half - 1))
		else $error("shortest move too long");

	wrap_on_c:   cover property (@(posedge clk) ce && rng.on && positionReady);
	move_c:      cover property (@(posedge clk) moveValid);
	pls_c:       cover property (@(posedge clk) plsFlag[0]);
	stop_c:      cover property (@(posedge clk) motionStop);

endmodule

// ---- sim/mpu_encoder_model.sv ----
// Multiturn feedback device model for the modulo position unit bench
module mpu_encoder_model
	import mpu_pkg::*;
#(
	parameter int FB_RANGE = 32'h0000_0FA0
)
(
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset,
	// Bench controls
	input  wire logic signed [POS_W-1:0] startAbs,
	input  wire logic signed [POS_W-1:0] stepVal,
	// Feedback side
	output logic                         fbReadValid,
	output logic signed [POS_W-1:0]      fbReadPosition,
	output logic signed [POS_W-1:0]      fbDelta
);
	timeunit 1ns;
	timeprecision 1ns;

	logic sent_ff;

	// One readout per power-up; value folded into the feedback span
	always_ff @(posedge clk) begin
		if (reset) begin
			sent_ff        <= 1'b0;
			fbReadValid    <= 1'b0;
			fbReadPosition <= ~startAbs;
		end else if (!sent_ff) begin
			sent_ff        <= 1'b1;
			fbReadValid    <= 1'b1;
			fbReadPosition <= startAbs % FB_RANGE;
		end else begin
			fbReadValid    <= 1'b0;
			// Stale readout is not held, so no use of it can pass by luck
			fbReadPosition <= ~fbReadPosition;
		end
	end

	assign fbDelta = stepVal;
endmodule

// ---- sim/modulo_position_unit_tb_top.sv ----
// Self-checking bench of the modulo position unit
module modulo_position_unit_tb_top;
	import mpu_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int FBR = 32'h0000_0FA0;
	localparam logic signed [31:0] BIG = 32'sh0010_0000;
	typedef struct packed {
		logic                    en;
		logic signed [POS_W-1:0] bA, bB, start, cmd, swP, swN, wLo, wHi, thr;
	} mpu_row_t;

	logic clk, reset, capA, capB, mvStart, en, ceOn;
	logic [OPMODE_W-1:0] mode;
	logic signed [POS_W-1:0] bA, bB, startAbs, stepVal, cmd, tgt, swP, swN;
	mpu_dir_t dir;
	mpu_win_t [PLS_N-1:0] win;
	mpu_dout_cfg_t [DOUT_N-1:0] dcfg;
	logic fbV, rdy, mvV, mvPos, pH, nH, stop;
	logic signed [POS_W-1:0] fbP, fbD, act, cmdO, capAO, capBO;
	logic signed [VEL_W-1:0] vel;
	logic signed [POS_W:0] mvD;
	logic [PLS_N-1:0] pls;
	logic [DOUT_N-1:0] dout;
	int error_cnt, num_checks;
	longint curLo, curLen;
	bit curOn;
	mpu_row_t rows [4] = '{
		'{1'b0, 32'h0, 32'h7D0, 32'h9C4, 32'hA28, BIG, -BIG,
			32'h960, 32'hA28, 32'h7D0},
		'{1'b1, 32'h7D0, 32'h0, 32'h251C, 32'h1004, 32'h1388, -32'sh5,
			32'h578, 32'h640, 32'h3E8},
		'{1'b1, 32'h0, 32'h9C4, 32'h2328, 32'h0, 32'h320, -32'sh3E8,
			32'hBB8, 32'hC1C, 32'hBB8},
		'{1'b1, -32'sh1F4, 32'h1F4, 32'hED8, 32'h0, 32'h190, -32'sh64,
			-32'shFA, -32'sh64, -32'shC8}};

	mpu_encoder_model #(.FB_RANGE(FBR)) u_enc (.clk(clk), .reset(reset),
		.startAbs(startAbs), .stepVal(stepVal), .fbReadValid(fbV),
		.fbReadPosition(fbP), .fbDelta(fbD));

	mpu_modulo_unit u_dut (.clk(clk), .reset(reset), .ce(ceOn),
		.operatingModeSelect(mode),
		.positionGains('{16'sh0100, KI_DEFAULT, KFF_DEFAULT, 32'sh5,
			-32'sh5}),
		.fbReadValid(fbV), .fbReadPosition(fbP), .fbDelta(fbD),
		.commandedPositionRaw(cmd), .wrapEnable(en), .wrapBoundA(bA),
		.wrapBoundB(bB), .absoluteMoveDirection(dir),
		.captureAStrobe(capA), .captureBStrobe(capB),
		.absMoveStart(mvStart), .absMoveTarget(tgt), .swLimitPos(swP),
		.swLimitNeg(swN), .plsWindow(win), .doutConfig(dcfg),
		.positionReady(rdy), .velocityCommand(vel), .actualPosition(act),
		.commandedPosition(cmdO), .captureAPosition(capAO),
		.captureBPosition(capBO), .moveValid(mvV), .moveDistance(mvD),
		.moveDirPositive(mvPos), .swLimitPosHit(pH), .swLimitNegHit(nH),
		.motionStop(stop), .plsFlag(pls), .digitalOut(dout));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic give_verdict();
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(string nm, logic signed [POS_W:0] seen,
		logic signed [POS_W:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %0d seen %0d", nm, exp, seen);
		end
	endtask

	function automatic longint wrapOf(longint p);
		longint m;
		if (!curOn)
			return p;
		m = (p - curLo) % curLen;
		if (m < 0)
			m += curLen;
		return curLo + m;
	endfunction

	function automatic bit inRng(longint v);
		return !curOn || (v >= curLo && v < curLo + curLen);
	endfunction

	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Drives one configuration and powers the unit up on it
	task automatic load(mpu_row_t r);
		int n;
		@(posedge clk);
		en <= r.en; bA <= r.bA; bB <= r.bB; startAbs <= r.start;
		cmd <= r.cmd; swP <= r.swP; swN <= r.swN;
		dcfg[0].thr <= r.thr; dcfg[1].thr <= r.thr;
		for (int i = 0; i < PLS_N; i++)
			win[i] <= '{r.wLo, r.wHi + 32'sh64 * i};
		curLo = (r.bA < r.bB) ? r.bA : r.bB;
		curLen = ((r.bA < r.bB) ? r.bB : r.bA) - curLo;
		curOn = r.en && curLen != 0;
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		n = 0;
		while (rdy !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		if (n >= 20) begin
			error_cnt++;
			give_verdict();
		end
		cyc(2);
	endtask

	task automatic step(logic signed [POS_W-1:0] d, int n);
		@(posedge clk) stepVal <= d;
		repeat (n) @(posedge clk);
		stepVal <= 32'h0;
		cyc(2);
	endtask

	task automatic move(int d, longint t, bit ok);
		longint e;
		@(posedge clk);
		dir <= mpu_dir_t'(d); tgt <= t[POS_W-1:0]; mvStart <= 1'b1;
		@(posedge clk) mvStart <= 1'b0;
		#1;
		chk("moveValid", mvV, ok);
		e = wrapOf(t) - wrapOf(act);
		if ((d == 0 && e < 0) || (d == 2 && e < -curLen / 2))
			e += curLen;
		else if ((d == 1 && e > 0) || (d == 2 && e > curLen / 2))
			e -= curLen;
		if (ok) begin
			chk("moveDistance", mvD, e);
			chk("moveDirPositive", mvPos, e > 0);
		end
	endtask

	// ************************************************************
	// Stimulus
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		longint rd, a;
		logic [PLS_N-1:0] fl;
		mpu_row_t r;
		bit sp;
		reset = 1'b1; mode = OPMODE_POSITION; en = 1'b0; bA = 0; bB = 0;
		ceOn = 1'b1;
		startAbs = 0; stepVal = 0; cmd = 0; tgt = 0; swP = 0; swN = 0;
		capA = 0; capB = 0; mvStart = 0; dir = DIR_POSITIVE; win = '0;
		dcfg = '{'{DOUT_MODE_LT, 32'h0}, '{DOUT_MODE_GT, 32'h0}};
		error_cnt = 0; num_checks = 0;
		foreach (rows[k]) begin
			r = rows[k];
			load(r);
			rd = r.start % FBR;
			a = wrapOf(rd);
			for (int i = 0; i < PLS_N; i++)
				fl[i] = inRng(r.wLo) && inRng(r.wHi + 100 * i) &&
					a >= r.wLo && a <= r.wHi + 100 * i;
			sp = (inRng(r.swP) && a > r.swP) || (inRng(r.swN) && a < r.swN);
			chk("positionReady", rdy, 1);
			chk("actualPosition", act, a);
			chk("commandedPosition", cmdO, wrapOf(r.cmd));
			chk("swLimitPosHit", pH, inRng(r.swP) && a > r.swP);
			chk("swLimitNegHit", nH, inRng(r.swN) && a < r.swN);
			chk("motionStop", stop, sp);
			chk("plsFlag", pls, fl);
			chk("digitalOut", dout, {a < r.thr, a > r.thr});
			chk("velocityCommand", vel, sp ? 0 : r.cmd - rd);
		end
		// Roll-over past the range end, captures and linear fallback
		load('{1'b1, 32'h0, 32'h3E8, 32'h3DE, 32'h0, BIG, -BIG,
			32'h0, 32'h0, 32'h0});
		step(32'h5, 4);
		chk("actualRoll", act, 32'hA);
		@(posedge clk) capA <= 1'b1;
		@(posedge clk) capA <= 1'b0;
		step(32'h64, 5);
		@(posedge clk) capB <= 1'b1;
		@(posedge clk) capB <= 1'b0;
		cyc(2);
		chk("captureAPosition", capAO, 32'hA);
		chk("captureBPosition", capBO, 32'h1FE);
		@(posedge clk) en <= 1'b0;
		cyc(2);
		chk("actualLinear", act, 32'h5E6);
		// Clock enable low must freeze the feedback sum
		@(posedge clk) ceOn <= 1'b0;
		step(32'h5, 3);
		chk("freezeHold", act, 32'h5E6);
		@(posedge clk) ceOn <= 1'b1;
		@(posedge clk) en <= 1'b1;
		cyc(2);
		for (int d = 0; d < 4; d++) begin
			move(d, 0, 1'b1);
			move(d, 32'h3B6, 1'b1);
		end
		// Loop and move planner idle outside position mode
		@(posedge clk) mode <= 4'h1;
		cyc(2);
		chk("velocityIdle", vel, 0);
		move(2, 32'h3B6, 1'b0);
		give_verdict();
	end
endmodule
